/* rtl/eeprom_cmd_defs.svh */
// Opcodes, status bit positions, address fields and protect bounds
`ifndef EEPROM_CMD_DEFS_SVH
`define EEPROM_CMD_DEFS_SVH
`define OP_SET_WRITE_LATCH   8'h06
`define OP_CLEAR_WRITE_LATCH 8'h04
`define OP_STATUS_READ       8'h05
`define OP_STATUS_WRITE      8'h01
`define OP_ARRAY_READ        8'h03
`define OP_ARRAY_WRITE       8'h02
`define OP_IDPAGE_READ       8'h83
`define OP_IDPAGE_WRITE      8'h82
`define SR_LOCK_BIT          7
`define SR_PROT_HI_BIT       3
`define SR_PROT_LO_BIT       2
`define SR_WEL_BIT           1
`define SR_BUSY_BIT          0
`define ADDR_LOCK_SEL_BIT    10
`define PROT_QUARTER_BASE    14'h3000
`define PROT_HALF_BASE       14'h2000
`define WRITE_CYCLE_NS       4000000
`define CLOCK_PERIOD_NS      100
`define WRITE_CYCLE_CYCLES   (`WRITE_CYCLE_NS / `CLOCK_PERIOD_NS)
`endif

/* rtl/eeprom_cmd_pkg.sv */
// Types shared by the command decoder, its checker and the testbench
package eeprom_cmd_pkg;
  typedef enum logic [4:0] {
    ST_OPCODE = 5'b00001,
    ST_ADDR   = 5'b00010,
    ST_DATA   = 5'b00100,
    ST_READ   = 5'b01000,
    ST_WAIT   = 5'b10000
  } frame_state_t;
  typedef enum logic [2:0] {
    WK_ARRAY  = 3'b001,
    WK_STATUS = 3'b010,
    WK_IDPAGE = 3'b100
  } write_kind_t;
endpackage : eeprom_cmd_pkg

/* rtl/write_cycle_timer.sv */
// Self-timed write cycle counter on the system clock
`timescale 1ns/1ps
module write_cycle_timer #(
  parameter int unsigned CYCLES = 40000
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  logic [31:0] count_q;

  // Down counter; done pulses one cycle as busy drops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 32'h0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        count_q <= CYCLES - 32'h1;
        busy    <= 1'b1;
      end else if (busy) begin
        if (count_q == 32'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_q <= count_q - 32'h1;
        end
      end
    end
  end
endmodule : write_cycle_timer

/* rtl/spi_eeprom_command_protect.sv */
// SPI EEPROM command decoder, write latch, status and block protect
// Two clock domains: the serial clock runs the framing logic, the system
// clock runs the latch, status bits and write launch. A finished command
// crosses by a toggle and a two-stage synchroniser; the captured opcode,
// address and data stay still while select is high, so they are safe to
// read once the toggle has arrived. Status bits cross the other way
// without a handshake; they move only at command or cycle end.
`timescale 1ns/1ps
`include "eeprom_cmd_defs.svh"
module spi_eeprom_command_protect
  import eeprom_cmd_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `WRITE_CYCLE_CYCLES,
  parameter logic [7:0]  MAKER_CODE   = 8'hA5, // Arbitrary value
  parameter logic [7:0]  FAMILY_CODE  = 8'h5A, // Arbitrary value
  parameter logic [7:0]  DENSITY_CODE = 8'h3C  // Arbitrary value
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        serial_clock,
  input  wire logic        select_n,
  input  wire logic        data_in,
  output logic             data_out,
  output logic             data_out_en,
  input  wire logic        write_protect_n,
  output logic             write_start,
  output eeprom_cmd_pkg::write_kind_t write_kind,
  output logic [13:0]      write_addr,
  output logic [7:0]       write_data,
  output logic             write_data_valid,
  output logic             write_busy_flag
);
  import eeprom_cmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link side: runs on serial clock, select acts as frame reset
  ////////////////////////////////////////////////////////////////////////////
  frame_state_t fstate_q;
  logic [2:0]   bit_cnt_q;
  logic [7:0]   shift_q;
  logic [7:0]   opcode_q;
  logic [15:0]  addr_q;
  logic         addr_hi_q;
  logic [7:0]   data_q;
  logic [7:0]   out_q;
  logic [5:0]   id_ptr_q;
  logic         armed_q;
  logic         cmd_tgl_q;
  logic [7:0]   cmd_op_q;
  logic         data_seen_q;
  logic         on_boundary_q;
  logic [7:0]   in_byte;
  logic [7:0]   status_view;
  logic [7:0]   id_page [0:63];
  logic         clr_armed_tgl_q;

  assign in_byte = {shift_q[6:0], data_in};

  // Select high marks frame end; armed set only by a seen select rise
  always_ff @(posedge select_n or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1; // A rise now means the next fall is a true edge
    end
  end

  // Byte framing and command decode on the serial clock rising edge
  always_ff @(posedge serial_clock or posedge select_n) begin
    if (select_n) begin
      fstate_q      <= ST_OPCODE;
      bit_cnt_q     <= 3'h0;
      shift_q       <= 8'h00;
      addr_hi_q     <= 1'b0;
      data_seen_q   <= 1'b0;
      on_boundary_q <= 1'b1;
    end else if (armed_q) begin // Ignored until a real falling edge
      shift_q       <= in_byte; // MSB first
      bit_cnt_q     <= bit_cnt_q + 3'h1;
      on_boundary_q <= (bit_cnt_q == 3'h7); // Whole bytes only
      if (bit_cnt_q == 3'h7) begin
        // Last bit of a byte: advance the frame decode
        unique case (fstate_q)
          ST_OPCODE: begin
            opcode_q <= in_byte;
            unique case (in_byte)
              `OP_SET_WRITE_LATCH, `OP_CLEAR_WRITE_LATCH:
                fstate_q <= ST_WAIT;
              `OP_STATUS_READ: fstate_q <= ST_READ;
              `OP_STATUS_WRITE: fstate_q <= ST_DATA;
              `OP_ARRAY_READ, `OP_ARRAY_WRITE,
              `OP_IDPAGE_READ, `OP_IDPAGE_WRITE: fstate_q <= ST_ADDR;
              default: fstate_q <= ST_WAIT; // Unknown opcode
            endcase
          end
          ST_ADDR: begin
            if (!addr_hi_q) begin
              addr_q[15:8] <= in_byte;
              addr_hi_q    <= 1'b1;
            end else begin
              addr_q[7:0] <= in_byte; // Two address bytes
              fstate_q    <= (opcode_q[0]) ? ST_READ : ST_DATA;
            end
          end
          ST_DATA: begin
            data_q      <= in_byte;
            data_seen_q <= 1'b1; // At least one data byte
          end
          ST_READ: ; // Shifting out continues till select rises
          ST_WAIT: ;
        endcase
      end
    end
  end

  // Frame-end command capture: counts only complete, framed commands
  // Old armed value is read here, so the power-up frame never counts
  always_ff @(posedge select_n or negedge reset_n) begin
    if (!reset_n) begin
      cmd_tgl_q <= 1'b0;
      cmd_op_q  <= 8'h00;
    end else if (armed_q && on_boundary_q) begin // Off-boundary drop
      if ((fstate_q == ST_WAIT && (opcode_q == `OP_SET_WRITE_LATCH ||
           opcode_q == `OP_CLEAR_WRITE_LATCH)) ||
          (fstate_q == ST_DATA && data_seen_q)) begin
        cmd_tgl_q <= ~cmd_tgl_q;
        cmd_op_q  <= opcode_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the system clock
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] cmd_sync_q;
  logic       cmd_seen_q;
  logic [1:0] wp_sync_q;
  logic       wel_q;
  logic       lock_q;
  logic [1:0] prot_q;
  logic [1:0] prot_new_q;
  logic       lock_new_q;
  logic       sr_pending_q;
  logic       timer_busy;
  logic       timer_done;
  logic       cmd_event;
  logic       prot_hit;
  logic [13:0] frame_addr;

  assign frame_addr = addr_q[13:0]; // Bits 15..14 ignored
  assign cmd_event  = cmd_sync_q[1] ^ cmd_seen_q;

  // Block protect decode for the addressed location
  function automatic logic protected_at(input logic [1:0] sel,
                                        input logic [13:0] a,
                                        input logic is_id);
    unique case (sel)
      2'b00: protected_at = 1'b0;
      2'b01: protected_at = !is_id && (a >= `PROT_QUARTER_BASE);
      2'b10: protected_at = !is_id && (a >= `PROT_HALF_BASE);
      default: protected_at = 1'b1; // Whole array and ID page
    endcase
  endfunction : protected_at

  assign prot_hit = protected_at(prot_q, frame_addr,
                                 cmd_op_q == `OP_IDPAGE_WRITE);

  // Two-stage synchronisers for the command toggle and protect pin
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmd_sync_q <= 2'b00;
      cmd_seen_q <= 1'b0;
      wp_sync_q  <= 2'b11;
    end else begin
      cmd_sync_q <= {cmd_sync_q[0], cmd_tgl_q};
      cmd_seen_q <= cmd_sync_q[1];
      wp_sync_q  <= {wp_sync_q[0], write_protect_n};
    end
  end

  // Write enable latch, status bits and write launch
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wel_q            <= 1'b0; // Cleared at power-up
      lock_q           <= 1'b0;
      prot_q           <= 2'b00;
      prot_new_q       <= 2'b00;
      lock_new_q       <= 1'b0;
      sr_pending_q     <= 1'b0;
      write_start      <= 1'b0;
      write_kind       <= WK_ARRAY;
      write_addr       <= 14'h0000;
      write_data       <= 8'h00;
      write_data_valid <= 1'b0;
    end else begin
      write_start      <= 1'b0;
      write_data_valid <= 1'b0;
      if (timer_done) begin
        wel_q <= 1'b0; // Completed write clears latch
        if (sr_pending_q) begin
          lock_q       <= lock_new_q; // Applied after cycle
          prot_q       <= prot_new_q;
          sr_pending_q <= 1'b0;
        end
      end
      if (cmd_event) begin
        unique case (cmd_op_q)
          `OP_SET_WRITE_LATCH: if (!timer_busy) wel_q <= 1'b1;
          `OP_CLEAR_WRITE_LATCH: wel_q <= 1'b0; // Even when busy
          `OP_STATUS_WRITE: begin
            // Lock with pin low freezes, in either order
            if (wel_q && !timer_busy && (!lock_q || wp_sync_q[1])) begin
              lock_new_q   <= data_q[`SR_LOCK_BIT];
              prot_new_q   <= data_q[`SR_PROT_HI_BIT:`SR_PROT_LO_BIT];
              sr_pending_q <= 1'b1;
              write_start  <= 1'b1;
              write_kind   <= WK_STATUS;
            end
          end
          `OP_ARRAY_WRITE, `OP_IDPAGE_WRITE: begin
            // Latch gates execution; protected area rejected
            if (wel_q && !timer_busy && !prot_hit) begin
              write_start      <= 1'b1;
              write_kind       <= (cmd_op_q == `OP_ARRAY_WRITE) ?
                                  WK_ARRAY : WK_IDPAGE;
              write_addr       <= frame_addr;
              write_data       <= data_q;
              write_data_valid <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  write_cycle_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .clock   (clock),
    .reset_n (reset_n),
    .start   (write_start),
    .busy    (timer_busy),
    .done    (timer_done)
  );

  // Busy flag registered for the status view and output
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      write_busy_flag <= 1'b0;
    end else begin
      write_busy_flag <= timer_busy | write_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: slow quasi-static status read across domains
  ////////////////////////////////////////////////////////////////////////////
  // Status bits move rarely against the byte time; sampled at byte load
  assign status_view = {lock_q, 3'b000, prot_q, wel_q, write_busy_flag};
  // Bits six to four tied low

  // ID page contents; only the code bytes are modelled here
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      id_page[i] = 8'h00;
    end
    id_page[0] = MAKER_CODE;
    id_page[1] = FAMILY_CODE;
    id_page[2] = DENSITY_CODE;
  end

  // Output byte reload on each byte edge of a read command
  always_ff @(posedge serial_clock or posedge select_n) begin
    if (select_n) begin
      out_q    <= 8'h00;
      id_ptr_q <= 6'h00;
    end else if (armed_q && bit_cnt_q == 3'h7) begin
      if (fstate_q == ST_OPCODE && in_byte == `OP_STATUS_READ) begin
        out_q <= status_view; // Repeated while select low
      end else if (fstate_q == ST_READ && opcode_q == `OP_STATUS_READ) begin
        out_q <= status_view;
      end else if ((fstate_q == ST_ADDR && addr_hi_q &&
                    opcode_q == `OP_IDPAGE_READ) ||
                   (fstate_q == ST_READ && opcode_q == `OP_IDPAGE_READ)) begin
        // Address bit ten selects a zero byte over page data
        // High address byte is already held when the low byte ends
        if (fstate_q == ST_ADDR && addr_q[`ADDR_LOCK_SEL_BIT]) begin
          out_q <= 8'h00;
        end else if (fstate_q == ST_ADDR) begin
          out_q    <= id_page[in_byte[5:0]];
          id_ptr_q <= in_byte[5:0] + 6'h1;
        end else begin
          out_q    <= id_page[id_ptr_q];
          id_ptr_q <= id_ptr_q + 6'h1;
        end
      end else begin
        out_q <= 8'h00; // Array data lives outside this block
      end
    end else begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  // Drive data out on the falling edge, MSB first
  // Falling edge gives the master a full half period of setup
  always_ff @(negedge serial_clock or posedge select_n) begin
    if (select_n) begin
      data_out    <= 1'b0;
      data_out_en <= 1'b0;
    end else begin
      data_out    <= out_q[7];
      data_out_en <= armed_q && (fstate_q == ST_READ);
    end
  end
endmodule : spi_eeprom_command_protect

/* tb/cmd_checker_assertions.sv */
// Checker for write launch and busy timing at the block's ports
`timescale 1ns/1ps
module cmd_checker
  import eeprom_cmd_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = 20
) (
  input wire logic                        clock,
  input wire logic                        reset_n,
  input wire logic                        select_n,
  input wire logic                        data_out_en,
  input wire logic                        write_start,
  input wire eeprom_cmd_pkg::write_kind_t write_kind,
  input wire logic                        write_data_valid,
  input wire logic                        write_busy_flag
);
  logic [31:0] busy_cnt_q;
  // Busy length counter, cleared while idle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_q <= '0;
    end else begin
      busy_cnt_q <= write_busy_flag ? busy_cnt_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_BUSY_AFTER_START: assert property (
    write_start |=> write_busy_flag) else $error("no busy after start");
  AST_START_PULSE: assert property (
    write_start |=> !write_start) else $error("start longer than one");
  AST_NO_START_BUSY: assert property (
    write_busy_flag |-> !write_start) else $error("start while busy");
  AST_BUSY_CAUSE: assert property (
    $rose(write_busy_flag) |-> $past(write_start))
    else $error("busy without start");
  AST_BUSY_LEN: assert property (
    $fell(write_busy_flag) |-> busy_cnt_q == WRITE_CYCLES + 1)
    else $error("busy length wrong");
  AST_BUSY_BOUND: assert property (
    busy_cnt_q <= WRITE_CYCLES + 1) else $error("busy too long");
  AST_OUT_EN_DESELECTED: assert property (
    select_n |-> !data_out_en) else $error("driving while deselected");
  AST_VALID_PAIR: assert property (
    write_data_valid |-> write_start && write_kind != WK_STATUS)
    else $error("data valid out of place");
  AST_KIND_ONEHOT: assert property (
    write_start |-> $onehot(write_kind)) else $error("kind not one-hot");
  AST_START_DESELECTED: assert property (
    write_start |-> select_n && $past(select_n))
    else $error("start while selected");
endmodule : cmd_checker

bind spi_eeprom_command_protect cmd_checker #(.WRITE_CYCLES(WRITE_CYCLES))
  chk (.clock(clock), .reset_n(reset_n), .select_n(select_n),
       .data_out_en(data_out_en),
       .write_start(write_start), .write_kind(write_kind),
       .write_data_valid(write_data_valid),
       .write_busy_flag(write_busy_flag));

/* tb/spi_master_model.sv */
// Bus master model sending SPI mode 0 frames
`timescale 1ns/1ps
module spi_master_model (
  output logic     serial_clock,
  output logic     select_n,
  output logic     data_in,
  input wire logic data_out
);
  // Select starts low, as a master holding it through power-up
  initial begin
    serial_clock = 1'b0;
    select_n = 1'b0;
    data_in = 1'b0;
  end
  // MSB first out on falling clock, read back on rising clock
  task automatic frame(input logic [39:0] bits, input int n,
                       output logic [39:0] rd);
    rd = '0;
    select_n = 1'b0;
    #7;
    for (int i = n - 1; i >= 0; i--) begin
      data_in = bits[i];
      #3;
      serial_clock = 1'b1;
      rd = {rd[38:0], data_out};
      #3;
      serial_clock = 1'b0;
    end
    // Long hold so the slow side surely sees the frame
    #300;
    select_n = 1'b1;
    data_in = ~data_in;
  endtask : frame
endmodule : spi_master_model

/* tb/tb.sv */
// Testbench: latch, framing, protect and status checks
`timescale 1ns/1ps
module tb;
  import eeprom_cmd_pkg::*;
  logic        clock, reset_n, write_protect_n, serial_clock, select_n;
  logic        data_in, data_out, data_out_en, write_start;
  logic        write_data_valid, write_busy_flag, lock_e;
  write_kind_t write_kind;
  logic [13:0] write_addr;
  logic [7:0]  write_data, d;
  logic [1:0]  prot_e;
  logic [15:0] a, bnd;
  logic [39:0] rd;
  int          failures, samples_checked, seed;
  spi_eeprom_command_protect #(.WRITE_CYCLES(20)) DUT (
    .clock(clock), .reset_n(reset_n), .serial_clock(serial_clock),
    .select_n(select_n), .data_in(data_in), .data_out(data_out),
    .data_out_en(data_out_en), .write_protect_n(write_protect_n),
    .write_start(write_start), .write_kind(write_kind),
    .write_addr(write_addr), .write_data(write_data),
    .write_data_valid(write_data_valid),
    .write_busy_flag(write_busy_flag));
  spi_master_model master (.serial_clock(serial_clock),
    .select_n(select_n), .data_in(data_in), .data_out(data_out));
  initial clock = 1'b0;
  always #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp,
                       input string what);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // Expected status byte from the model's lock and protect bits
  function automatic logic [7:0] stat(input logic write_enable_latch, input logic busy);
    return {lock_e, 3'h0, prot_e, write_enable_latch, busy};
  endfunction : stat
  task automatic idle(input int k);
    repeat (k) @(posedge clock);
    #5;
  endtask : idle
  task automatic send(input logic [39:0] bits, input int n);
    master.frame(bits, n, rd);
    idle(3);
  endtask : send
  // Two copies read back while select stays low
  task automatic read_status(input logic [7:0] exp);
    send(40'h050000, 24);
    check(rd[15:0], {exp, exp}, "status");
  endtask : read_status
  task automatic do_write(input logic latch, input logic [39:0] bits,
                          input int n, input logic ok, input write_kind_t k);
    int t;
    if (latch) send(40'h06, 8);
    master.frame(bits, n, rd);
    t = 0;
    while (write_start !== 1'b1 && t < 8) begin
      idle(1);
      t++;
    end
    check(write_start, ok, "launch");
    if (ok) begin
      check(write_kind, k, "kind");
      if (k != WK_STATUS) check({write_data_valid, bits[21:0]},
        {1'b1, write_addr, write_data}, "addr data");
      idle(2);
      read_status(stat(1'b1, 1'b1));
      t = 0;
      do begin
        send(40'h050000, 24);
        t++;
      end while (rd[0] !== 1'b0 && t < 20);
      check(rd[0], 1'b0, "busy poll");
      if (k == WK_STATUS) begin
        lock_e = bits[7];
        prot_e = bits[3:2];
      end
    end else begin
      idle(2);
      send(40'h04, 8);
    end
    read_status(stat(1'b0, 1'b0));
  endtask : do_write
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #1_000_000;
    failures++;
    finish_test();
  end
  initial begin
    seed = 42024;
    failures = 0;
    samples_checked = 0;
    lock_e = 1'b0;
    prot_e = 2'h0;
    reset_n = 1'b0;
    write_protect_n = 1'b1;
    repeat (4) @(posedge clock);
    #5;
    reset_n = 1'b1;
    idle(2);
    // Select low through reset, so this opcode is dropped
    send(40'h06, 8);
    read_status(stat(1'b0, 1'b0));
    send(40'h06, 8);
    read_status(stat(1'b1, 1'b0));
    send(40'h04, 8);
    read_status(stat(1'b0, 1'b0));
    do_write(1'b0, 40'h0200105A, 32, 1'b0, WK_ARRAY);
    do_write(1'b1, 40'h0100082D, 31, 1'b0, WK_ARRAY);
    do_write(1'b1, 40'h020010, 24, 1'b0, WK_ARRAY);
    for (int i = 0; i < 4; i++) begin
      a = 16'($random(seed));
      d = 8'($random(seed));
      do_write(1'b1, {8'h02, a, d}, 32, 1'b1, WK_ARRAY);
    end
    // Clear-latch in mid cycle leaves the cycle running
    send(40'h06, 8);
    send(40'h020123A5, 32);
    idle(4);
    send(40'h04, 8);
    read_status(stat(1'b0, 1'b1));
    idle(25);
    write_protect_n = 1'b0;
    do_write(1'b1, 40'h01FF, 16, 1'b1, WK_STATUS);
    do_write(1'b1, 40'h0100, 16, 1'b0, WK_STATUS);
    do_write(1'b1, 40'h02000011, 32, 1'b0, WK_ARRAY);
    do_write(1'b1, 40'h82000511, 32, 1'b0, WK_IDPAGE);
    write_protect_n = 1'b1;
    for (int p = 1; p < 3; p++) begin
      do_write(1'b1, {8'h01, 4'h0, p[1:0], 2'h0}, 16, 1'b1,
               WK_STATUS);
      bnd = (p == 1) ? 16'h3000 : 16'h2000;
      do_write(1'b1, {8'h02, bnd, 8'hC3}, 32, 1'b0, WK_ARRAY);
      do_write(1'b1, {8'h02, bnd - 16'h1, 8'h3C}, 32, 1'b1,
               WK_ARRAY);
    end
    do_write(1'b1, 40'h82000577, 32, 1'b1, WK_IDPAGE);
    send(40'hFF06, 16);
    read_status(stat(1'b0, 1'b0));
    send(40'h8300000000, 40);
    check(rd[15:0], 16'hA55A, "id bytes");
    finish_test();
  end
endmodule : tb
